// file: hw/osb_pkg.sv
// Constants, types and decode helpers for the oscillator select and boot
// clock block. Assumes a 200 MHz pclk and an APB register port.
// Overview of operation
// - Each of the three oscillators has its own enable bit: crystal bit 7, fast RC bit 4, slow RC bit 2.
// - Once boot completes with a calibrated option the slow RC is running, and the fast RC too for all but the slow option.
// - A trim register adjusts the fast RC frequency, usually to 16 MHz.
// - Select values 0x34, 0x14 and 0x3c give the fast RC divided by 2, 4 and 8 with it enabled.
// - Select values 0x1c and 0x7c give the fast RC divided by 16 and 32.
// - Select value 0xe4 gives the slow RC undivided with the fast RC off and the slow RC on.
// - The trim routine runs only in the one-time memory write pass and never on later boots.
// - A calibrated option leaves boot with watchdog off, slow RC on and the shared pin an input.
// - With trim disabled the select stays as it was, fast RC untrimmed and off, watchdog on.
// - After power-on the boot delay is either a fast or a normal period.
// - A select write switches the clock after one edge of the new source, and the source in use cannot be shut off.
// - The crystal drive field gives low, middle and high drive for 01, 10 and 11.
package osb_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_CLKSEL = 8'h00;
    localparam logic [7:0] ADDR_XTAL = 8'h04;
    localparam logic [7:0] ADDR_TRIM = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;

    // Field positions
    localparam int XTAL_EN_BIT = 7;
    localparam int DRV_LSB = 5;
    localparam int FAST_EN_BIT = 4;
    localparam int SLOW_EN_BIT = 2;

    // Values after reset
    localparam logic [7:0] CLKSEL_RST = 8'he4;
    localparam logic [7:0] XTAL_RST = 8'h00;
    localparam logic [7:0] TRIM_RST = 8'h80;

    // Select values loaded by the calibrated boot options
    localparam logic [7:0] SEL_FAST_DIV2 = 8'h34;
    localparam logic [7:0] SEL_FAST_DIV4 = 8'h14;
    localparam logic [7:0] SEL_FAST_DIV8 = 8'h3c;
    localparam logic [7:0] SEL_FAST_DIV16 = 8'h1c;
    localparam logic [7:0] SEL_FAST_DIV32 = 8'h7c;
    localparam logic [7:0] SEL_SLOW = 8'he4;

    // Boot delays and their cycle counts at pclk
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned BOOT_NORMAL_US = 55000;
    localparam int unsigned BOOT_FAST_US = 850;
    localparam int unsigned BOOT_NORMAL_CYC = BOOT_NORMAL_US * CLK_MHZ;
    localparam int unsigned BOOT_FAST_CYC = BOOT_FAST_US * CLK_MHZ;

    // Synchronised input vector layout
    localparam int N_IN = 16;
    localparam int IN_TRIM_LSB = 0;
    localparam int IN_OPT_LSB = 8;
    localparam int IN_WRITE_MODE = 11;
    localparam int IN_FAST_BOOT = 12;
    localparam int IN_FAST_CLK = 13;
    localparam int IN_SLOW_CLK = 14;
    localparam int IN_XTAL_CLK = 15;

    // Boot trim options
    localparam logic [2:0] OPT_DIV2 = 3'h0;
    localparam logic [2:0] OPT_DIV4 = 3'h1;
    localparam logic [2:0] OPT_DIV8 = 3'h2;
    localparam logic [2:0] OPT_DIV16 = 3'h3;
    localparam logic [2:0] OPT_DIV32 = 3'h4;
    localparam logic [2:0] OPT_SLOW = 3'h5;

    typedef enum logic [1:0] {
        SRC_FAST = 2'h0,
        SRC_SLOW = 2'h1,
        SRC_XTAL = 2'h2,
        SRC_NONE = 2'h3
    } osb_src_t;

    typedef struct packed {
        osb_src_t src;
        logic [2:0] div_log2;
    } osb_sel_t;

    typedef struct packed {
        logic xtal_en;
        logic [1:0] xtal_drive;
        logic fast_en;
        logic slow_en;
    } osb_osc_t;

    // Select register to source and divider
    function automatic osb_sel_t osb_decode(input logic [7:0] v);
        osb_sel_t s;
        s = '{src: SRC_NONE, div_log2: 3'h0};
        unique case ({v[7:5], v[3]})
            4'h2: s = '{src: SRC_FAST, div_log2: 3'h1};
            4'h0: s = '{src: SRC_FAST, div_log2: 3'h2};
            4'h3: s = '{src: SRC_FAST, div_log2: 3'h3};
            4'h1: s = '{src: SRC_FAST, div_log2: 3'h4};
            4'h7: s = '{src: SRC_FAST, div_log2: 3'h5};
            4'h6: s = '{src: SRC_FAST, div_log2: 3'h6};
            4'he, 4'hf: s = '{src: SRC_SLOW, div_log2: 3'h0};
            4'ha, 4'hb: s = '{src: SRC_XTAL, div_log2: 3'h0};
            default: s = '{src: SRC_NONE, div_log2: 3'h0};
        endcase
        return s;
    endfunction

    // Calibrated option to select value
    function automatic logic [7:0] osb_opt_sel(input logic [2:0] opt);
        logic [7:0] v;
        v = SEL_SLOW;
        unique case (opt)
            OPT_DIV2: v = SEL_FAST_DIV2;
            OPT_DIV4: v = SEL_FAST_DIV4;
            OPT_DIV8: v = SEL_FAST_DIV8;
            OPT_DIV16: v = SEL_FAST_DIV16;
            OPT_DIV32: v = SEL_FAST_DIV32;
            default: v = SEL_SLOW;
        endcase
        return v;
    endfunction

endpackage

// file: hw/osb_clock_ctrl.sv
// Oscillator enables, system clock select and divide, and boot state.
// Assumes APB from the core, oscillator ticks and boot straps on pins.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module osb_clock_ctrl #(
    parameter int unsigned BOOT_NORMAL_CYC = osb_pkg::BOOT_NORMAL_CYC,
    parameter int unsigned BOOT_FAST_CYC = osb_pkg::BOOT_FAST_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fast_rc_osc,
    input wire logic slow_rc_osc,
    input wire logic crystal_osc,
    input wire logic fast_boot,
    input wire logic otp_write_mode,
    input wire logic [2:0] trim_option,
    input wire logic [7:0] otp_trim_word,
    output osb_pkg::osb_osc_t osc_ctrl,
    output logic [7:0] fast_rc_trim,
    output logic trim_run,
    output logic sys_clk_en,
    output logic watchdog_en,
    output logic shared_reset_pin_input,
    output logic boot_done
);

    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_APPLY = 3'b010,
        ST_RUN = 3'b100
    } osb_state_t;

    // Pin synchroniser stages and oscillator edge detect
    logic [osb_pkg::N_IN-1:0] pins;
    logic [osb_pkg::N_IN-1:0] sync1;
    logic [osb_pkg::N_IN-1:0] sync2;
    logic [osb_pkg::N_IN-1:0] sync3;
    logic [osb_pkg::N_IN-1:0] filt;
    logic [2:0] tick_prev;
    logic [2:0] ticks;

    // Boot sequencer
    osb_state_t state;
    osb_state_t next_state;
    logic [23:0] boot_cnt;
    logic [23:0] boot_limit;
    logic calibrated;

    // Software registers
    logic [7:0] clksel;
    logic [7:0] xtal;

    // Source select and divider; armed stays low until the new source
    // has shown one edge, so the first enable after a switch is a full period
    osb_pkg::osb_sel_t sel;
    osb_pkg::osb_sel_t sel_q;
    logic [5:0] div_cnt;
    logic [5:0] div_mask;
    logic src_tick;
    logic armed;

    // APB handshake and read path
    logic access;
    logic wr_fire;
    logic [31:0] rd_mux;
    logic rd_bad;

    assign pins = {crystal_osc, slow_rc_osc, fast_rc_osc, fast_boot,
                   otp_write_mode, trim_option, otp_trim_word};

    // Three-stage sync, value taken once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < osb_pkg::N_IN; g++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1[g] <= 1'b0;
                    sync2[g] <= 1'b0;
                    sync3[g] <= 1'b0;
                    filt[g] <= 1'b0;
                end else begin
                    sync1[g] <= pins[g];
                    sync2[g] <= sync1[g];
                    sync3[g] <= sync2[g];
                    if (sync2[g] == sync3[g]) begin
                        filt[g] <= sync3[g];
                    end
                end
            end
        end
    endgenerate

    // Rising edges of the three oscillator inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_prev <= 3'h0;
        end else begin
            tick_prev <= filt[osb_pkg::IN_XTAL_CLK:osb_pkg::IN_FAST_CLK];
        end
    end
    assign ticks = filt[osb_pkg::IN_XTAL_CLK:osb_pkg::IN_FAST_CLK] & ~tick_prev;

    // Boot delay selection and option class
    assign boot_limit = filt[osb_pkg::IN_FAST_BOOT] ?
                        24'(BOOT_FAST_CYC - 1) : 24'(BOOT_NORMAL_CYC - 1);
    assign calibrated = filt[osb_pkg::IN_OPT_LSB+2 -: 3] <= osb_pkg::OPT_SLOW;

    // Boot sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            ST_WAIT: begin
                if (boot_cnt >= boot_limit) begin
                    next_state = ST_APPLY;
                end
            end
            ST_APPLY: next_state = ST_RUN;
            ST_RUN: next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_WAIT;
        end else begin
            state <= next_state;
        end
    end

    // Boot delay counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_cnt <= 24'h0;
        end else if (state == ST_WAIT) begin
            boot_cnt <= boot_cnt + 24'h1;
        end
    end

    // APB handshake: one wait state, then answer
    assign access = psel && penable;
    assign wr_fire = access && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access && !pready;
        end
    end

    // Read data mux and unmapped detection
    always_comb begin
        rd_mux = 32'h0;
        rd_bad = 1'b0;
        unique case (paddr)
            osb_pkg::ADDR_CLKSEL: rd_mux = {24'h0, clksel};
            osb_pkg::ADDR_XTAL: rd_mux = {24'h0, xtal};
            osb_pkg::ADDR_TRIM: rd_mux = {24'h0, fast_rc_trim};
            osb_pkg::ADDR_STATUS: rd_mux = {24'h0, boot_done, watchdog_en,
                                           sel.src, sel.div_log2,
                                           filt[osb_pkg::IN_WRITE_MODE]};
            default: rd_bad = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            prdata <= pwrite ? 32'h0 : rd_mux;
            pslverr <= rd_bad;
        end
    end

    // Clock select register
    // A calibrated boot apply wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clksel <= osb_pkg::CLKSEL_RST;
        end else if (state == ST_APPLY && calibrated) begin
            clksel <= osb_pkg::osb_opt_sel(filt[osb_pkg::IN_OPT_LSB+2 -: 3]);
        end else if (wr_fire && pstrb[0] && paddr == osb_pkg::ADDR_CLKSEL) begin
            clksel <= pwdata[7:0];
        end
    end

    // Crystal control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal <= osb_pkg::XTAL_RST;
        end else if (wr_fire && pstrb[0] && paddr == osb_pkg::ADDR_XTAL) begin
            xtal <= pwdata[7:0];
        end
    end

    // Fast RC trim register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_rc_trim <= osb_pkg::TRIM_RST;
        end else if (state == ST_APPLY && calibrated &&
                     !filt[osb_pkg::IN_WRITE_MODE]) begin
            fast_rc_trim <= filt[osb_pkg::IN_TRIM_LSB+7 -: 8];
        end else if (wr_fire && pstrb[0] && paddr == osb_pkg::ADDR_TRIM) begin
            fast_rc_trim <= pwdata[7:0];
        end
    end

    // Trim routine only in the one-time memory write pass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_run <= 1'b0;
        end else begin
            trim_run <= state == ST_APPLY && calibrated &&
                        filt[osb_pkg::IN_WRITE_MODE];
        end
    end

    // Boot outcome: watchdog, shared pin, done flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_en <= 1'b1;
            shared_reset_pin_input <= 1'b1;
            boot_done <= 1'b0;
        end else if (state == ST_APPLY) begin
            watchdog_en <= !calibrated;
            shared_reset_pin_input <= 1'b1;
            boot_done <= 1'b1;
        end
    end

    // Oscillator enables; the source in use stays on
    assign sel = osb_pkg::osb_decode(clksel);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_ctrl <= '0;
        end else begin
            osc_ctrl.xtal_en <= xtal[osb_pkg::XTAL_EN_BIT] ||
                                sel.src == osb_pkg::SRC_XTAL;
            osc_ctrl.xtal_drive <= xtal[osb_pkg::DRV_LSB+1 -: 2];
            osc_ctrl.fast_en <= clksel[osb_pkg::FAST_EN_BIT] ||
                                sel.src == osb_pkg::SRC_FAST;
            osc_ctrl.slow_en <= clksel[osb_pkg::SLOW_EN_BIT] ||
                                sel.src == osb_pkg::SRC_SLOW;
        end
    end

    // Selected source tick and divider terminal count
    always_comb begin
        unique case (sel.src)
            osb_pkg::SRC_FAST: src_tick = ticks[0];
            osb_pkg::SRC_SLOW: src_tick = ticks[1];
            osb_pkg::SRC_XTAL: src_tick = ticks[2];
            default: src_tick = 1'b0;
        endcase
    end
    assign div_mask = 6'((7'h1 << sel.div_log2) - 7'h1);

    // Divider: restarts on a select change so no period is cut short
    // Without the arming step an edge of the new source just after the switch
    // would give an enable only a few cycles after the last one of the old source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= '{src: osb_pkg::SRC_NONE, div_log2: 3'h0};
            div_cnt <= 6'h0;
            armed <= 1'b0;
            sys_clk_en <= 1'b0;
        end else begin
            sel_q <= sel;
            sys_clk_en <= 1'b0;
            if (sel != sel_q) begin
                div_cnt <= 6'h0;
                armed <= 1'b0;
            end else if (src_tick) begin
                if (!armed) begin
                    armed <= 1'b1; // First edge only aligns the count
                end else if (div_cnt >= div_mask) begin
                    div_cnt <= 6'h0;
                    sys_clk_en <= 1'b1;
                end else begin
                    div_cnt <= div_cnt + 6'h1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// file: sim/osb_clock_ctrl_chk.sv
// Port-level assertions for the clock control block.
// Assumes binding onto osb_clock_ctrl; one pclk domain.
`timescale 1ns/100ps
`default_nettype none
module osb_clock_ctrl_chk #(
    parameter int unsigned BOOT_NORMAL_CYC = 40,
    parameter int unsigned BOOT_FAST_CYC = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire osb_pkg::osb_osc_t osc_ctrl,
    input wire logic trim_run,
    input wire logic sys_clk_en,
    input wire logic watchdog_en,
    input wire logic shared_reset_pin_input,
    input wire logic boot_done,
    input wire logic fast_boot,
    input wire logic [2:0] trim_option
);
    int cnt;
    int lim;
    logic wr_take;
    // Cycles since reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
        end else if (cnt < 100000) begin
            cnt <= cnt + 1;
        end
    end
    // Boot length in force and write acceptance
    assign lim = fast_boot ? int'(BOOT_FAST_CYC) : int'(BOOT_NORMAL_CYC);
    assign wr_take = psel && penable && pready && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence boot_end_s;
        $rose(boot_done);
    endsequence
    ready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    unmapped_err_a: assert property (psel && penable && !pready
        && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}) |=> pready && pslverr)
        else $error("no error on unmapped access");
    fast_en_a: assert property (wr_take && paddr == 8'h00 && pwdata[4] |-> ##2 osc_ctrl.fast_en)
        else $error("fast enable lost");
    slow_en_a: assert property (wr_take && paddr == 8'h00 && pwdata[2] |-> ##2 osc_ctrl.slow_en)
        else $error("slow enable lost");
    xtal_ctl_a: assert property (wr_take && paddr == 8'h04 |-> ##2
        osc_ctrl.xtal_en == $past(pwdata[7], 2) && osc_ctrl.xtal_drive == $past(pwdata[6:5], 2))
        else $error("crystal control mismatch");
    trim_once_a: assert property (boot_done |=> !trim_run)
        else $error("trim after boot");
    trim_at_boot_a: assert property (trim_run |-> $rose(boot_done))
        else $error("trim outside boot end");
    boot_state_a: assert property (boot_end_s |->
        watchdog_en == (trim_option > 3'h5) && shared_reset_pin_input)
        else $error("boot state wrong");
    rc_state_a: assert property (boot_end_s |=>
        osc_ctrl.slow_en && (osc_ctrl.fast_en == (trim_option < 3'h5)))
        else $error("oscillator enables wrong after boot");
    boot_time_a: assert property (boot_end_s |-> cnt >= lim && cnt <= lim + 8)
        else $error("boot length wrong");
    clk_gap_a: assert property (sys_clk_en |=> !sys_clk_en [*8])
        else $error("short clock period");
endmodule
bind osb_clock_ctrl osb_clock_ctrl_chk #(.BOOT_NORMAL_CYC(BOOT_NORMAL_CYC),
    .BOOT_FAST_CYC(BOOT_FAST_CYC)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .osc_ctrl(osc_ctrl), .trim_run(trim_run), .sys_clk_en(sys_clk_en),
    .watchdog_en(watchdog_en), .shared_reset_pin_input(shared_reset_pin_input),
    .boot_done(boot_done), .fast_boot(fast_boot), .trim_option(trim_option));
`default_nettype wire

// file: sim/test_osc_select_and_boot_clock.sv
// Self-checking bench for the clock control block over APB.
// Assumes the package and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_osc_select_and_boot_clock;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trim_run, sys_clk_en;
    logic watchdog_en, pin_in, boot_done, fast_rc, slow_rc, xtal, fast_boot, wmode, er;
    logic [7:0] paddr, trim_word, trim_out;
    logic [2:0] opt;
    logic [31:0] pwdata, prdata, rd;
    osb_pkg::osb_osc_t osc;
    int failures, n_checks, cyc, n_trim;
    logic [7:0] sel_tab [8] = '{8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'he4, 8'he4, 8'he4};

    osb_clock_ctrl #(.BOOT_NORMAL_CYC(40), .BOOT_FAST_CYC(10)) u_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fast_rc_osc(fast_rc), .slow_rc_osc(slow_rc), .crystal_osc(xtal),
        .fast_boot(fast_boot), .otp_write_mode(wmode), .trim_option(opt),
        .otp_trim_word(trim_word), .osc_ctrl(osc), .fast_rc_trim(trim_out),
        .trim_run(trim_run), .sys_clk_en(sys_clk_en), .watchdog_en(watchdog_en),
        .shared_reset_pin_input(pin_in), .boot_done(boot_done));

    // Clock at 200 MHz
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Oscillator waves locked to pclk, and trim pulse count
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        fast_rc <= (cyc % 10 == 9) ? ~fast_rc : fast_rc;
        slow_rc <= (cyc % 32 == 31) ? ~slow_rc : slow_rc;
        xtal <= (cyc % 12 == 11) ? ~xtal : xtal;
        n_trim <= n_trim + int'(trim_run === 1'b1);
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Final report
    task automatic conclude();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            failures++;
            conclude();
        end
    endtask

    // Register read and compare
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Reset with given straps, wait for boot, judge the state left
    task automatic boot(input logic [2:0] o, input logic fb, input logic wm);
        int k;
        int t0;
        k = 0;
        t0 = n_trim;
        @(posedge pclk);
        presetn <= 1'b0;
        opt <= o;
        fast_boot <= fb;
        wmode <= wm;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        while (boot_done !== 1'b1 && k < 200) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 200) begin
            failures++;
            conclude();
        end
        chk(k, fb ? 32'hc : 32'h2a);
        // Enables follow the applied select one edge after done
        repeat (2) @(posedge pclk);
        chk(watchdog_en, o > 3'h5);
        chk(pin_in, 1'b1);
        chk(osc.fast_en, o < 3'h5);
        chk(osc.slow_en, 1'b1);
        chk(n_trim - t0, (o < 3'h6 && wm) ? 1 : 0);
        rchk(8'h00, sel_tab[o]);
        rchk(8'h08, (o < 3'h6 && !wm) ? trim_word : 8'h80);
        chk(trim_out, (o < 3'h6 && !wm) ? trim_word : 8'h80);
    endtask

    // Interval between two system clock enables
    task automatic per(input int exp);
        int n;
        repeat (2) begin
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (sys_clk_en !== 1'b1 && n < 1500);
        end
        chk(n, exp);
        if (n >= 1500) begin
            conclude();
        end
    endtask

    // Each boot select value plus 0xf4 and 0xa6: readback, decoded status, enable and period
    // 0xf4 moves to the slow RC with the fast RC still on before it is stopped
    task automatic sel_scan();
        logic [7:0] v [8] = '{8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'hf4, 8'he4, 8'ha6};
        logic [4:0] e [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h08, 5'h08, 5'h10};
        int p [8] = '{40, 80, 160, 320, 640, 64, 64, 24};
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 8'h00, {24'h0, v[i]});
            rchk(8'h00, v[i]);
            apb(1'b0, 8'h0c, 32'h0);
            chk(rd[5:1], e[i]);
            chk(osc.fast_en, v[i][4]);
            per(p[i]);
        end
    endtask

    // Crystal enable and every drive level, slow RC as source so that the
    // select does not hold the crystal on; crystal kept on across the switch
    task automatic xtal_scan();
        apb(1'b1, 8'h04, 32'h80);
        apb(1'b1, 8'h00, 32'he4);
        for (int d = 0; d < 4; d++) begin
            apb(1'b1, 8'h04, ((d != 0) ? 32'h80 : 32'h0) | (d << 5));
            repeat (2) @(posedge pclk);
            chk({osc.xtal_en, osc.xtal_drive}, {d != 0, 2'(d)});
        end
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fast_rc = 1'b0;
        slow_rc = 1'b0;
        xtal = 1'b0;
        fast_boot = 1'b1;
        wmode = 1'b0;
        opt = 3'h6;
        trim_word = 8'h5a;
        cyc = 0;
        n_trim = 0;
        failures = 0;
        n_checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        boot(3'h6, 1'b1, 1'b0);
        rchk(8'h04, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        for (int o = 0; o < 6; o++) begin
            boot(3'(o), 1'b1, 1'b0);
        end
        boot(3'h0, 1'b1, 1'b1);
        boot(3'h7, 1'b0, 1'b0);
        sel_scan();
        xtal_scan();
        conclude();
    end
endmodule
`default_nettype wire
